// [scp_fifo.sv]
`timescale 1ns/1ps
module scp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   // ********************************************************************
   // Pointers carry one extra bit to tell full from empty
   // ********************************************************************
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      wr_next;
   logic [AW:0]      rd_reg;
   logic [AW:0]      rd_next;
   logic             push;
   logic             pop;

   assign out_valid = (wr_reg != rd_reg);
   assign in_ready  = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_reg[rd_reg[AW-1:0]];

   always_comb begin
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data;
      end
   end

endmodule : scp_fifo

// [scp_partner.sv]
`timescale 1ns/1ps
// ***********************************************************
// Far side: external master, or attached device and memory
// ***********************************************************
module scp_partner (
   input  wire logic clk,
   input  wire logic sclk_pin,
   input  wire logic sel_n_pin,
   input  wire logic sdo_pin,
   input  wire logic dev_drives,
   output logic      p_sclk,
   output logic      p_sel_n,
   output logic      p_din
);
   logic [7:0]  tx_rot = 8'ha5;
   logic [31:0] cap    = 32'h0;
   int          ncap   = 0;

   initial begin
      p_sclk = 1'b0;
      p_sel_n = 1'b1;
      p_din = 1'b1;
   end

   // Answer 8'ha5 msb first, data moving on each falling clock
   always @(negedge sel_n_pin) begin
      cap <= 32'h0;
      ncap <= 0;
      if (dev_drives) begin
         p_din <= 1'b1;
         tx_rot <= 8'h4b;
      end
   end
   always @(negedge sclk_pin) if (dev_drives && !sel_n_pin) begin
      p_din <= tx_rot[7];
      tx_rot <= {tx_rot[6:0], tx_rot[7]};
   end
   // Only the first 32 bits of an access are kept, enough for a boot header
   always @(posedge sclk_pin) if (dev_drives && !sel_n_pin && ncap < 32) begin
      cap <= {cap[30:0], sdo_pin};
      ncap <= ncap + 1;
   end
   // A released data line shows the inverse, never the last value
   always @(posedge sel_n_pin) p_din <= ~p_din;

   task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge clk);
      p_sel_n <= 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         p_din <= word[i];
         repeat (4) @(posedge clk);
         p_sclk <= 1'b1;
         repeat (4) @(posedge clk);
         if (i < 8) rd = {rd[6:0], sdo_pin};
         p_sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      p_sel_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : frame
endmodule : scp_partner

// [scp_pkg.sv]
// ********************************************************************
// Constants shared by the serial CPU port
// ********************************************************************
package scp_pkg;

   localparam int CLK_PERIOD_NS = 100;
   // Shortest half period of the serial clock when the port drives it
   localparam int SCK_HALF_NS   = 400;
   localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] DIV_MIN = 8'(SCK_HALF_CYC);

   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 9;

   localparam logic [4:0] CNT_ADDR_DONE  = 5'h08;
   localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
   localparam logic [2:0] BIT_LAST       = 3'h7;

   localparam logic [1:0] BOOT_CFG_SERIAL = 2'h1;
   localparam logic [7:0] BOOT_READ_CMD   = 8'h03;
   localparam logic [2:0] BOOT_HDR_BYTES  = 3'h4;
   localparam logic [1:0] STRAP_WAIT      = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SLAVE,
      ST_NEXT,
      ST_LOW,
      ST_HIGH,
      ST_HOLD
   } scp_state_e;

endpackage : scp_pkg

// [scp_serial_port.sv]
`timescale 1ns/1ps
module scp_serial_port
   import scp_pkg::*;
#(
   parameter logic [23:0] BOOT_ADDR = 24'h000000
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       role_master,
   input  wire logic [1:0] boot_config_inputs,
   input  wire logic       boot_finish,
   output logic            boot_active,
   output logic      [7:0] boot_data,
   output logic            boot_valid,
   input  wire logic       boot_ready,
   output logic      [6:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic [7:0] m_tx_data,
   input  wire logic       m_tx_last,
   input  wire logic       m_tx_valid,
   output logic            m_tx_ready,
   output logic      [7:0] m_rx_data,
   output logic            m_rx_valid,
   output logic            m_busy,
   input  wire logic [7:0] cfg_div,
   input  wire logic       cfg_lsb_first,
   input  wire logic       sclk_i,
   output logic            sclk_o,
   output logic            sclk_oe,
   input  wire logic       serial_port_select_n_i,
   output logic            serial_port_select_n_o,
   output logic            serial_port_select_n_oe,
   input  wire logic       serial_port_data_in,
   output logic            sdo_o,
   output logic            sdo_oe
);
   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic       sclk_d_reg;
   logic       sclk_s;
   logic       cs_s;
   logic       din_s;
   logic [1:0] cfg_s;
   logic       rise;
   logic       fall;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg  <= 5'h00;
         sync2_reg  <= 5'h1f;
         sclk_d_reg <= 1'b1;
      end else begin
         sync1_reg  <= {boot_config_inputs, serial_port_data_in, serial_port_select_n_i, sclk_i};
         sync2_reg  <= sync1_reg;
         sclk_d_reg <= sync2_reg[0];
      end
   end

   assign sclk_s = sync2_reg[0];
   assign cs_s   = sync2_reg[1];
   assign din_s  = sync2_reg[2];
   assign cfg_s  = sync2_reg[4:3];
   assign rise   = sclk_s && !sclk_d_reg;
   assign fall   = !sclk_s && sclk_d_reg;

   // ********************************************************************
   // Master transmit buffer: word is {last, byte}
   // ********************************************************************
   logic [8:0] fifo_data;
   logic       fifo_valid;
   logic       fifo_pop;

   scp_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_data   ({m_tx_last, m_tx_data}),
      .in_valid  (m_tx_valid),
      .in_ready  (m_tx_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // ********************************************************************
   // Port state
   // ********************************************************************
   function automatic logic out_bit(input logic [7:0] b, input logic lsb);
      out_bit = lsb ? b[0] : b[7];
   endfunction : out_bit

   function automatic logic [7:0] boot_hdr(input logic [2:0] idx);
      case (idx)
         3'h0:    boot_hdr = BOOT_READ_CMD;
         3'h1:    boot_hdr = BOOT_ADDR[23:16];
         3'h2:    boot_hdr = BOOT_ADDR[15:8];
         3'h3:    boot_hdr = BOOT_ADDR[7:0];
         default: boot_hdr = 8'h00;
      endcase
   endfunction : boot_hdr

   scp_state_e st_reg,     st_next;
   logic       strap_reg,  strap_next;
   logic [1:0] wait_reg,   wait_next;
   logic       boot_reg,   boot_next;
   logic [2:0] bidx_reg,   bidx_next;
   logic       cs_reg,     cs_next;
   logic       sclk_reg,   sclk_next;
   logic       sdo_reg,    sdo_next;
   logic [7:0] div_reg,    div_next;
   logic [2:0] bit_reg,    bit_next;
   logic [7:0] tx_reg,     tx_next;
   logic [7:0] rx_reg,     rx_next;
   logic       lsb_reg,    lsb_next;
   logic       last_reg,   last_next;
   logic       mrv_reg,    mrv_next;
   logic [4:0] scnt_reg,   scnt_next;
   logic [7:0] ssh_reg,    ssh_next;
   logic       srd_reg,    srd_next;
   logic [7:0] stx_reg,    stx_next;
   logic [6:0] raddr_reg,  raddr_next;
   logic [7:0] rwdata_reg, rwdata_next;
   logic       rwr_reg,    rwr_next;
   logic       rrd_reg,    rrd_next;
   logic [7:0] eff_div;
   logic       div_end;
   logic [7:0] tx_sel;

   assign eff_div  = (cfg_div < DIV_MIN) ? DIV_MIN : cfg_div;
   assign div_end  = (div_reg == eff_div - 8'h01);
   assign fifo_pop = (st_reg == ST_NEXT) && !boot_reg;

   always_comb begin
      st_next     = st_reg;
      strap_next  = strap_reg;
      wait_next   = wait_reg;
      boot_next   = boot_reg;
      bidx_next   = bidx_reg;
      cs_next     = cs_reg;
      sclk_next   = sclk_reg;
      sdo_next    = sdo_reg;
      div_next    = div_reg;
      bit_next    = bit_reg;
      tx_next     = tx_reg;
      rx_next     = rx_reg;
      lsb_next    = lsb_reg;
      last_next   = last_reg;
      mrv_next    = 1'b0;
      scnt_next   = scnt_reg;
      ssh_next    = ssh_reg;
      srd_next    = srd_reg;
      stx_next    = rrd_reg ? reg_rdata : stx_reg;
      raddr_next  = raddr_reg;
      rwdata_next = rwdata_reg;
      rwr_next    = 1'b0;
      rrd_next    = 1'b0;
      tx_sel      = boot_reg ? ((bidx_reg < BOOT_HDR_BYTES) ? boot_hdr(bidx_reg) : 8'h00) : fifo_data[7:0];
      case (st_reg)
         ST_IDLE: begin
            if (!strap_reg) begin
               wait_next = wait_reg + 2'h1;
               if (wait_reg == STRAP_WAIT) begin
                  strap_next = 1'b1;
                  if (cfg_s == BOOT_CFG_SERIAL) begin
                     boot_next = 1'b1;
                     bidx_next = 3'h0;
                     cs_next   = 1'b0;
                     st_next   = ST_NEXT;
                  end else if (!role_master) begin
                     // Go straight to slave so the pins are never driven against an external master
                     st_next   = ST_SLAVE;
                  end
               end
            end else if (role_master) begin
               if (fifo_valid) begin
                  cs_next = 1'b0;
                  st_next = ST_NEXT;
               end
            end else begin
               st_next = ST_SLAVE;
            end
         end
         ST_SLAVE: begin
            if (cs_s) begin
               scnt_next = 5'h00;
               srd_next  = 1'b0;
               if (role_master) begin
                  st_next = ST_IDLE;
               end
            end else if (rise) begin
               ssh_next  = {ssh_reg[6:0], din_s};
               scnt_next = scnt_reg + 5'h01;
               if (scnt_next == CNT_ADDR_DONE) begin
                  raddr_next = ssh_next[6:0];
                  srd_next   = ssh_next[7];
                  rrd_next   = ssh_next[7];
               end else if (scnt_next == CNT_FRAME_DONE && !srd_reg) begin
                  rwdata_next = ssh_next;
                  rwr_next    = 1'b1;
               end
            end else if (fall && srd_reg) begin
               sdo_next = stx_reg[7];
               stx_next = {stx_reg[6:0], 1'b0};
            end
         end
         ST_NEXT: begin
            if (boot_reg && boot_finish) begin
               boot_next = 1'b0;
               cs_next   = 1'b1;
               st_next   = ST_IDLE;
            end else if (boot_reg || fifo_valid) begin
               lsb_next  = !boot_reg && cfg_lsb_first;
               last_next = fifo_data[8];
               tx_next   = tx_sel;
               sdo_next  = out_bit(tx_sel, !boot_reg && cfg_lsb_first);
               div_next  = 8'h00;
               bit_next  = 3'h0;
               st_next   = ST_LOW;
            end
         end
         ST_LOW: begin
            div_next = div_reg + 8'h01;
            if (div_end) begin
               div_next  = 8'h00;
               sclk_next = 1'b1;
               rx_next   = lsb_reg ? {din_s, rx_reg[7:1]} : {rx_reg[6:0], din_s};
               st_next   = ST_HIGH;
            end
         end
         ST_HIGH: begin
            div_next = div_reg + 8'h01;
            if (div_end) begin
               div_next  = 8'h00;
               sclk_next = 1'b0;
               if (bit_reg != BIT_LAST) begin
                  bit_next = bit_reg + 3'h1;
                  tx_next  = lsb_reg ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
                  sdo_next = out_bit(tx_next, lsb_reg);
                  st_next  = ST_LOW;
               end else if (boot_reg) begin
                  if (bidx_reg < BOOT_HDR_BYTES) begin
                     bidx_next = bidx_reg + 3'h1;
                     st_next   = ST_NEXT;
                  end else begin
                     st_next = ST_HOLD;
                  end
               end else begin
                  mrv_next = 1'b1;
                  if (last_reg) begin
                     cs_next = 1'b1;
                     st_next = ST_IDLE;
                  end else begin
                     st_next = ST_NEXT;
                  end
               end
            end
         end
         ST_HOLD: begin
            if (boot_ready) begin
               st_next = ST_NEXT;
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg     <= ST_IDLE;
         strap_reg  <= 1'b0;
         wait_reg   <= 2'h0;
         boot_reg   <= 1'b0;
         bidx_reg   <= 3'h0;
         cs_reg     <= 1'b1;
         sclk_reg   <= 1'b0;
         sdo_reg    <= 1'b0;
         div_reg    <= 8'h00;
         bit_reg    <= 3'h0;
         tx_reg     <= 8'h00;
         rx_reg     <= 8'h00;
         lsb_reg    <= 1'b0;
         last_reg   <= 1'b0;
         mrv_reg    <= 1'b0;
         scnt_reg   <= 5'h00;
         ssh_reg    <= 8'h00;
         srd_reg    <= 1'b0;
         stx_reg    <= 8'h00;
         raddr_reg  <= 7'h00;
         rwdata_reg <= 8'h00;
         rwr_reg    <= 1'b0;
         rrd_reg    <= 1'b0;
      end else begin
         st_reg     <= st_next;
         strap_reg  <= strap_next;
         wait_reg   <= wait_next;
         boot_reg   <= boot_next;
         bidx_reg   <= bidx_next;
         cs_reg     <= cs_next;
         sclk_reg   <= sclk_next;
         sdo_reg    <= sdo_next;
         div_reg    <= div_next;
         bit_reg    <= bit_next;
         tx_reg     <= tx_next;
         rx_reg     <= rx_next;
         lsb_reg    <= lsb_next;
         last_reg   <= last_next;
         mrv_reg    <= mrv_next;
         scnt_reg   <= scnt_next;
         ssh_reg    <= ssh_next;
         srd_reg    <= srd_next;
         stx_reg    <= stx_next;
         raddr_reg  <= raddr_next;
         rwdata_reg <= rwdata_next;
         rwr_reg    <= rwr_next;
         rrd_reg    <= rrd_next;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   // Clock and select are only driven once the straps are taken and the port is not a slave
   assign sclk_o                  = sclk_reg;
   assign sclk_oe                 = strap_reg && (st_reg != ST_SLAVE);
   assign serial_port_select_n_o  = cs_reg;
   assign serial_port_select_n_oe = strap_reg && (st_reg != ST_SLAVE);
   assign sdo_o                   = sdo_reg;
   assign sdo_oe                  = (st_reg == ST_SLAVE && !cs_s && srd_reg)
                                 || st_reg == ST_LOW || st_reg == ST_HIGH;
   assign boot_active             = boot_reg;
   assign boot_data               = rx_reg;
   assign boot_valid              = (st_reg == ST_HOLD);
   assign m_rx_data               = rx_reg;
   assign m_rx_valid              = mrv_reg;
   assign m_busy                  = strap_reg && !boot_reg && st_reg != ST_IDLE && st_reg != ST_SLAVE;
   assign reg_addr                = raddr_reg;
   assign reg_wdata               = rwdata_reg;
   assign reg_wr                  = rwr_reg;
   assign reg_rd                  = rrd_reg;

endmodule : scp_serial_port

// [scp_serial_port_props.sv]
`timescale 1ns/1ps
// ***********************************************************
// Port-level properties of the serial CPU port
// ***********************************************************
module scp_serial_port_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic role_master,
   input wire logic boot_active,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic m_busy,
   input wire logic m_rx_valid,
   input wire logic sclk_o,
   input wire logic sclk_oe,
   input wire logic serial_port_select_n_i,
   input wire logic serial_port_select_n_o,
   input wire logic serial_port_select_n_oe,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // Six cycles leave room for the select synchroniser
   sequence s_sel_quiet;
      (serial_port_select_n_i && !serial_port_select_n_oe) [*6];
   endsequence
   sequence s_slave_idle;
      (!role_master && !boot_active) [*4];
   endsequence

   a_sdo_float_idle: assert property (s_sel_quiet |-> !sdo_oe)
      else $error("data output driven while deselected");
   a_slave_no_drive: assert property (s_slave_idle |-> !sclk_oe && !serial_port_select_n_oe)
      else $error("clock or select driven in slave role");
   a_sclk_half_min: assert property (sclk_oe && $changed(sclk_o) |=> $stable(sclk_o) [*3])
      else $error("serial clock half period too short");
   a_sdo_hold_high: assert property (sclk_oe && sdo_oe && $past(sclk_o) && sclk_o |-> $stable(sdo_o))
      else $error("data output moved while clock high");
   a_master_sel_low: assert property (m_busy |-> !serial_port_select_n_o && serial_port_select_n_oe && sclk_oe)
      else $error("select not low during master access");
   a_boot_hold_sel: assert property (boot_active && $past(boot_active) |-> !serial_port_select_n_o && sclk_oe)
      else $error("select not low during boot");
   a_boot_release: assert property ($fell(boot_active) |-> ##[0:2] (serial_port_select_n_o || !serial_port_select_n_oe))
      else $error("select not released after boot");
   a_rx_valid_pulse: assert property (m_rx_valid |-> $past(m_busy) ##1 !m_rx_valid)
      else $error("receive strobe outside an access");
   a_rd_in_frame: assert property (reg_rd |-> !serial_port_select_n_i && !sclk_oe ##1 !reg_rd)
      else $error("register read outside a slave frame");
   a_wr_slave_only: assert property (reg_wr |-> !sclk_oe && !boot_active ##1 !reg_wr)
      else $error("register write outside slave role");
endmodule : scp_serial_port_props

bind scp_serial_port scp_serial_port_props u_props (.clk(clk), .nrst(nrst), .role_master(role_master),
   .boot_active(boot_active), .reg_wr(reg_wr), .reg_rd(reg_rd), .m_busy(m_busy), .m_rx_valid(m_rx_valid),
   .sclk_o(sclk_o), .sclk_oe(sclk_oe), .serial_port_select_n_i(serial_port_select_n_i),
   .serial_port_select_n_o(serial_port_select_n_o), .serial_port_select_n_oe(serial_port_select_n_oe),
   .sdo_o(sdo_o), .sdo_oe(sdo_oe));

// [tb_serial_cpu_port.sv]
`timescale 1ns/1ps
// ***********************************************************
// Self-checking bench
// ***********************************************************
module tb_serial_cpu_port import scp_pkg::*;;
   localparam logic [23:0] TB_BOOT_ADDR = 24'h000120;
   logic       clk = 1'b0, nrst = 1'b0, role_master = 1'b0, boot_finish = 1'b0, boot_ready = 1'b0;
   logic [1:0] boot_config_inputs = 2'h0;
   logic [7:0] reg_rdata = 8'h00, m_tx_data = 8'h00, cfg_div = 8'h04, boot_data, reg_wdata, m_rx_data;
   logic       m_tx_last = 1'b0, m_tx_valid = 1'b0, cfg_lsb_first = 1'b0, refused = 1'b0;
   logic [6:0] reg_addr;
   logic       boot_active, boot_valid, reg_wr, reg_rd, m_tx_ready, m_rx_valid, m_busy, sclk_o, sclk_oe;
   logic       serial_port_select_n_o, serial_port_select_n_oe, sdo_o, sdo_oe, p_sclk, p_sel_n, p_din;
   logic [7:0] rx_last = 8'h00, boot_last = 8'h00;
   int         n_mismatch = 0, n_tests = 0, n_wr = 0, n_rd = 0, n_rxv = 0, n_boot = 0;
   wire        sclk_pin = sclk_oe ? sclk_o : p_sclk;
   wire        sel_pin  = serial_port_select_n_oe ? serial_port_select_n_o : p_sel_n;
   wire        sdo_pin  = sdo_oe ? sdo_o : ~sdo_o;

   always #50 clk = ~clk;

   scp_serial_port #(.BOOT_ADDR(TB_BOOT_ADDR)) dut_u (.clk(clk), .nrst(nrst), .role_master(role_master),
      .boot_config_inputs(boot_config_inputs), .boot_finish(boot_finish), .boot_active(boot_active),
      .boot_data(boot_data), .boot_valid(boot_valid), .boot_ready(boot_ready), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .m_tx_data(m_tx_data),
      .m_tx_last(m_tx_last), .m_tx_valid(m_tx_valid), .m_tx_ready(m_tx_ready), .m_rx_data(m_rx_data),
      .m_rx_valid(m_rx_valid), .m_busy(m_busy), .cfg_div(cfg_div), .cfg_lsb_first(cfg_lsb_first),
      .sclk_i(sclk_pin), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .serial_port_select_n_i(sel_pin),
      .serial_port_select_n_o(serial_port_select_n_o), .serial_port_select_n_oe(serial_port_select_n_oe),
      .serial_port_data_in(p_din), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
   scp_partner u_part (.clk(clk), .sclk_pin(sclk_pin), .sel_n_pin(sel_pin), .sdo_pin(sdo_pin),
      .dev_drives(serial_port_select_n_oe), .p_sclk(p_sclk), .p_sel_n(p_sel_n), .p_din(p_din));

   always @(posedge clk) begin
      if (reg_wr === 1'b1) n_wr++;
      if (reg_rd === 1'b1) n_rd++;
      if (m_rx_valid === 1'b1) begin
         n_rxv++;
         rx_last = m_rx_data;
      end
      if (boot_valid === 1'b1 && boot_ready === 1'b1) begin
         n_boot++;
         boot_last = boot_data;
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic do_reset(input logic [1:0] strap);
      nrst <= 1'b0;
      boot_config_inputs <= strap;
      repeat (8) @(posedge clk);
      check("oe in reset", 32'h0, {sclk_oe, serial_port_select_n_oe, sdo_oe});
      check("ready in reset", 32'h1, 32'(m_tx_ready));
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : do_reset

   task automatic wait_idle;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 3000 && m_busy !== 1'b0; k++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask : wait_idle

   task automatic push(input logic [8:0] w);
      m_tx_data <= w[7:0];
      m_tx_last <= w[8];
      m_tx_valid <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 2000 && m_tx_ready !== 1'b1; k++) begin
         refused = 1'b1;
         @(posedge clk);
      end
   endtask : push

   task automatic t_slave;
      logic [7:0] rd;
      int         w0;
      check("slave drives nothing", 32'h0, {sclk_oe, serial_port_select_n_oe, boot_active});
      w0 = n_wr;
      u_part.frame(16'h2a5c, 6, rd);
      check("partial frame", 32'(w0), 32'(n_wr));
      u_part.frame(16'h2a5c, 16, rd);
      check("write count", 32'(w0 + 1), 32'(n_wr));
      check("write target", 32'h2a5c, {reg_addr, reg_wdata});
      reg_rdata <= 8'hc3;
      u_part.frame(16'hab77, 16, rd);
      check("read count", 32'h1, 32'(n_rd));
      check("read addr and writes", {7'h2b, 25'(w0 + 1)}, {reg_addr, 25'(n_wr)});
      check("read data", 32'hc3, 32'(rd));
      check("sdo released", 32'h0, 32'(sdo_oe));
      $display("test slave done");
   endtask : t_slave

   task automatic t_master;
      int v0;
      v0 = n_rxv;
      role_master <= 1'b1;
      cfg_div <= 8'h02;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 10; k++) push({k == 9, 8'h10 + 8'(k)});
      m_tx_valid <= 1'b0;
      wait_idle();
      check("fifo refused when full", 32'h1, 32'(refused));
      check("bytes received", 32'(v0 + 10), 32'(n_rxv));
      check("received byte", 32'ha5, 32'(rx_last));
      check("bytes sent", 32'h10111213, u_part.cap);
      check("select released", 32'h1, 32'(sel_pin));
      cfg_lsb_first <= 1'b1;
      push({1'b1, 8'h01});
      m_tx_valid <= 1'b0;
      wait_idle();
      check("lsb first byte", 32'h80, u_part.cap);
      role_master <= 1'b0;
      $display("test master done");
   endtask : t_master

   task automatic t_boot;
      do_reset(BOOT_CFG_SERIAL);
      check("boot active", 32'h1, 32'(boot_active));
      check("boot select", 32'h0, 32'(sel_pin));
      boot_ready <= 1'b1;
      for (int k = 0; k < 3000 && n_boot < 2; k++) @(posedge clk);
      check("boot bytes", 32'h2, 32'(n_boot));
      check("boot data", 32'ha5, 32'(boot_last));
      check("boot header", {BOOT_READ_CMD, TB_BOOT_ADDR}, u_part.cap);
      boot_finish <= 1'b1;
      for (int k = 0; k < 200 && boot_active !== 1'b0; k++) @(posedge clk);
      repeat (3) @(posedge clk);
      check("boot released", 32'h1, {boot_active, sel_pin});
      boot_finish <= 1'b0;
      $display("test boot done");
   endtask : t_boot

   task automatic finish_test;
      $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("MISMATCH watchdog expected done seen hang");
      finish_test();
   end

   initial begin
      do_reset(2'h0);
      t_slave();
      t_master();
      t_boot();
      finish_test();
   end
endmodule : tb_serial_cpu_port
